/* logic/mbac_regs.svh */
// address map and limits of the mode based access controller
// assumes a flat 24-bit cpu address space shared by code, data and sfr accesses
`ifndef MBAC_REGS_SVH
`define MBAC_REGS_SVH
`define MBAC_ROM_LO 24'h000000
`define MBAC_ROM_HI 24'h02dfff
`define MBAC_FIRMWARE_VECTOR_LO 24'h000100
`define MBAC_FIRMWARE_VECTOR_HI 24'h00011c
`define MBAC_SVEC_LO 24'h000200
`define MBAC_SVEC_HI 24'h00027c
`define MBAC_DFLASH_LO 24'h100000
`define MBAC_DFLASH_HI 24'h107fff
`define MBAC_AFLASH_HI 24'h22ffff
`define MBAC_DEEP_LO 24'h300000
`define MBAC_DEEP_HI 24'h3002ff
`define MBAC_MFR_LO 24'h300300
`define MBAC_MFR_HI 24'h3005ff
`define MBAC_MFR_VIS_LO 24'h300500
`define MBAC_AEEP_HI 24'h31ffff
`define MBAC_DRAM_LO 24'h400000
`define MBAC_DRAM_HI 24'h4001ff
`define MBAC_GRAM_LO 24'h400200
`define MBAC_GRAM_HI 24'h407fff
`define MBAC_CRAM_LO 24'h408000
`define MBAC_CRAM_HI 24'h408a7f
`define MBAC_CRAM_SIZE 12'ha80
`define MBAC_VIRT_LO 24'h800000
`define MBAC_VIRT_HI 24'h807dff
`define MBAC_SFRHW_LO 24'hff0000
`define MBAC_SFRHW_HI 24'hff7fff
`define MBAC_SFRCT_LO 24'hff8000
`define MBAC_SFRCT_HI 24'hffffff
`define MBAC_SEG_COUNT 8
`define MBAC_SEG_MAX 16
`endif

/* logic/mbac_pkg.sv */
// types shared by the access controller files
// assumes mbac_regs.svh is on the include path
package mbac_pkg;
  typedef logic [23:0] mbac_addr_t;
  typedef enum logic [2:0] {
    mode_boot = 3'h0, mode_test = 3'h1, mode_fw = 3'h3, mode_sys = 3'h2, mode_user = 3'h6
  } mbac_mode_e;
  typedef enum logic [1:0] {kind_read = 2'h0, kind_write = 2'h1, kind_fetch = 2'h2} mbac_kind_e;
  typedef enum logic [3:0] {
    reg_none = 4'h0, reg_rom = 4'h1, reg_ded_flash = 4'h2, reg_app_flash = 4'h3,
    reg_ded_eep = 4'h4, reg_mfr_eep = 4'h5, reg_app_eep = 4'h6, reg_ded_ram = 4'h7,
    reg_gen_ram = 4'h8, reg_cop_ram = 4'h9, reg_sfr_hw = 4'ha, reg_sfr_ctrl = 4'hb
  } mbac_region_e;
  function automatic logic in_rng(input mbac_addr_t a, input mbac_addr_t lo, input mbac_addr_t hi);
    return (a >= lo) && (a <= hi);
  endfunction
endpackage

/* logic/mbac_region_decode.sv */
// physical address to memory partition decode
// assumes addresses are already translated out of the virtual data space
`timescale 1ns/1ns
`include "mbac_regs.svh"
module mbac_region_decode
  import mbac_pkg::*;
(
  input wire mbac_addr_t addr,
  output mbac_region_e region
);
  function automatic mbac_region_e decode(input mbac_addr_t a);
    mbac_region_e r;
    r = reg_none;
    if (in_rng(a, `MBAC_ROM_LO, `MBAC_ROM_HI)) r = reg_rom;
    else if (in_rng(a, `MBAC_DFLASH_LO, `MBAC_DFLASH_HI)) r = reg_ded_flash;
    else if (in_rng(a, `MBAC_DFLASH_LO, `MBAC_AFLASH_HI)) r = reg_app_flash;
    else if (in_rng(a, `MBAC_DEEP_LO, `MBAC_DEEP_HI)) r = reg_ded_eep;
    else if (in_rng(a, `MBAC_MFR_LO, `MBAC_MFR_HI)) r = reg_mfr_eep;
    else if (in_rng(a, `MBAC_DEEP_LO, `MBAC_AEEP_HI)) r = reg_app_eep;
    else if (in_rng(a, `MBAC_DRAM_LO, `MBAC_DRAM_HI)) r = reg_ded_ram;
    else if (in_rng(a, `MBAC_GRAM_LO, `MBAC_GRAM_HI)) r = reg_gen_ram;
    else if (in_rng(a, `MBAC_CRAM_LO, `MBAC_CRAM_HI)) r = reg_cop_ram;
    else if (in_rng(a, `MBAC_SFRHW_LO, `MBAC_SFRHW_HI)) r = reg_sfr_hw;
    else if (in_rng(a, `MBAC_SFRCT_LO, `MBAC_SFRCT_HI)) r = reg_sfr_ctrl;
    return r;
  endfunction

  assign region = decode(addr);
endmodule // mbac_region_decode

/* logic/mbac_segment_check.sv */
// software defined user segments: bounds, permissions and virtual translation
// assumes writes arrive already qualified by the privileged mode
`timescale 1ns/1ns
`include "mbac_regs.svh"
module mbac_segment_check
  import mbac_pkg::*;
#(
  parameter int SEG_COUNT = `MBAC_SEG_COUNT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_we,
  input wire logic [$clog2(SEG_COUNT)-1:0] cfg_idx,
  input wire mbac_addr_t cfg_base,
  input wire mbac_addr_t cfg_limit,
  input wire mbac_addr_t cfg_xlat,
  input wire logic [2:0] cfg_perm,
  input wire mbac_addr_t chk_addr,
  input wire mbac_kind_e chk_kind,
  output logic hit,
  output logic perm_ok,
  output mbac_addr_t xlat_addr
);
  generate
    if (SEG_COUNT < 2 || SEG_COUNT > `MBAC_SEG_MAX) begin : g_bad
      $error("segment count out of range");
    end
  endgenerate

  mbac_addr_t base_q [SEG_COUNT];
  mbac_addr_t limit_q [SEG_COUNT];
  mbac_addr_t xlat_q [SEG_COUNT];
  logic [2:0] perm_q [SEG_COUNT];
  logic [SEG_COUNT-1:0] hit_vec;
  logic [SEG_COUNT-1:0] ok_vec;
  mbac_addr_t xl_vec [SEG_COUNT];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < SEG_COUNT; i++) begin
        base_q[i] <= 24'h000000;
        limit_q[i] <= 24'h000000;
        xlat_q[i] <= 24'h000000;
        perm_q[i] <= 3'h0;
      end
    end else if (cfg_we) begin
      base_q[cfg_idx] <= cfg_base;
      limit_q[cfg_idx] <= cfg_limit;
      xlat_q[cfg_idx] <= cfg_xlat;
      perm_q[cfg_idx] <= cfg_perm;
    end
  end

  // a segment with no permission bit set counts as revoked and never hits
  genvar g;
  generate
    for (g = 0; g < SEG_COUNT; g++) begin : g_seg
      assign hit_vec[g] = in_rng(chk_addr, base_q[g], limit_q[g]) && (perm_q[g] != 3'h0);
      assign ok_vec[g] = perm_q[g][chk_kind];
      assign xl_vec[g] = chk_addr - base_q[g] + xlat_q[g];
    end
  endgenerate

  // lowest index wins where segments overlap
  always_comb begin
    hit = 1'b0;
    perm_ok = 1'b0;
    xlat_addr = chk_addr;
    for (int i = SEG_COUNT - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit = 1'b1;
        perm_ok = ok_vec[i];
        xlat_addr = xl_vec[i];
      end
    end
  end
endmodule // mbac_segment_check

/* logic/mbac_top.sv */
// cpu mode tracking and per access grant or refusal towards the memories
// assumes one cpu request per cycle, answered on the next edge; coprocessor port is trusted
`timescale 1ns/1ns
`include "mbac_regs.svh"
// Notes on behaviour
// R01: fetch of a firmware vector entry switches the cpu into firmware mode.
// R02: fetch of a system call vector entry switches the cpu into system mode.
// R03: rom and the dedicated flash part serve only dedicated software.
// R04: the dedicated eeprom part serves only dedicated software.
// R05: the dedicated ram part serves only dedicated software.
// R06: system mode reaches application memories fully; user mode only where granted.
// R07: system mode software sets up segments granting or revoking user access.
// R08: manufacturer eeprom area has own control; only its upper part is readable.
// R09: test mode reaches all application memories.
// R10: boot and firmware mode cannot read, write or fetch application memories; code lets granted firmware read and write app flash and eeprom.
// R11: firmware reaches application nonvolatile memory only after system mode grants it.
// R12: mode decides mapping; dedicated partitions hidden from system and user code.
// R13: user mode accesses to memories and hardware sfrs need a segment hit.
// R14: application ram splits into general region and coprocessor shared region.
// R15: coprocessor reaches its shared ram directly, without any check; the code drops requests with cop_offset at or above the shared ram size.
// R16: virtual data space maps to general ram, except user mode uses segments.
// R17: a refused access never reaches memory and raises a fault to the cpu.
module mbac_top
  import mbac_pkg::*;
#(
  parameter int SEG_COUNT = `MBAC_SEG_COUNT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire mbac_kind_e req_kind,
  input wire mbac_addr_t req_addr,
  input wire logic mode_leave,
  input wire logic test_enable,
  input wire logic seg_cfg_we,
  input wire logic [$clog2(SEG_COUNT)-1:0] seg_cfg_idx,
  input wire mbac_addr_t seg_cfg_base,
  input wire mbac_addr_t seg_cfg_limit,
  input wire mbac_addr_t seg_cfg_xlat,
  input wire logic [2:0] seg_cfg_perm,
  input wire logic fw_grant_we,
  input wire logic fw_grant_val,
  input wire logic cop_req,
  input wire logic cop_we,
  input wire logic [11:0] cop_offset,
  output mbac_mode_e mode,
  output logic mem_valid,
  output mbac_kind_e mem_kind,
  output mbac_addr_t mem_addr,
  output mbac_region_e mem_region,
  output logic fault,
  output mbac_addr_t fault_addr,
  output logic cfg_refused,
  output logic cop_mem_valid,
  output logic cop_mem_we,
  output mbac_addr_t cop_mem_addr
);
  mbac_mode_e mode_q, mode_d;
  logic fw_grant_q;
  logic mem_valid_q, fault_q, cfg_refused_q, cop_valid_q, cop_we_q;
  mbac_kind_e mem_kind_q;
  mbac_addr_t mem_addr_q, fault_addr_q, cop_addr_q;
  mbac_region_e mem_region_q;

  wire is_boot = (mode_q == mode_boot);
  wire is_test = (mode_q == mode_test);
  wire is_fw = (mode_q == mode_fw);
  wire is_sys = (mode_q == mode_sys);
  wire is_user = (mode_q == mode_user);
  wire is_fetch = (req_kind == kind_fetch);
  wire is_write = (req_kind == kind_write);
  wire aligned = (req_addr[1:0] == 2'h0);
  wire vec_fw = req_valid && is_fetch && aligned && in_rng(req_addr, `MBAC_FIRMWARE_VECTOR_LO, `MBAC_FIRMWARE_VECTOR_HI);
  wire vec_sys = req_valid && is_fetch && aligned && in_rng(req_addr, `MBAC_SVEC_LO, `MBAC_SVEC_HI);
  wire vec_any = vec_fw || vec_sys;

  // virtual data space translation
  wire virt = in_rng(req_addr, `MBAC_VIRT_LO, `MBAC_VIRT_HI);
  wire seg_hit;
  wire seg_perm_ok;
  mbac_addr_t seg_xlat;
  wire mbac_addr_t virt_phys = `MBAC_GRAM_LO + (req_addr - `MBAC_VIRT_LO); // R16
  wire mbac_addr_t eff_addr = !virt ? req_addr : (is_user ? seg_xlat : virt_phys); // R16
  mbac_region_e region;

  wire seg_we = seg_cfg_we && is_sys; // R07
  mbac_segment_check #(
    .SEG_COUNT(SEG_COUNT)
  ) u_seg (
    .clk(clk),
    .reset(reset),
    .cfg_we(seg_we),
    .cfg_idx(seg_cfg_idx),
    .cfg_base(seg_cfg_base),
    .cfg_limit(seg_cfg_limit),
    .cfg_xlat(seg_cfg_xlat),
    .cfg_perm(seg_cfg_perm),
    .chk_addr(req_addr),
    .chk_kind(req_kind),
    .hit(seg_hit),
    .perm_ok(seg_perm_ok),
    .xlat_addr(seg_xlat)
  );

  mbac_region_decode u_dec (
    .addr(eff_addr),
    .region(region)
  );

  // region classes; general and shared ram are both application ram
  wire r_ded_code = (region == reg_rom) || (region == reg_ded_flash); // R03
  wire r_ded_eep = (region == reg_ded_eep); // R04
  wire r_ded_ram = (region == reg_ded_ram); // R05
  wire r_ded = r_ded_code || r_ded_eep || r_ded_ram;
  wire r_app_ram = (region == reg_gen_ram) || (region == reg_cop_ram); // R14
  wire r_app = (region == reg_app_flash) || (region == reg_app_eep) || r_app_ram;
  wire r_mfr = (region == reg_mfr_eep);
  wire r_sfr_hw = (region == reg_sfr_hw);
  wire r_sfr_ct = (region == reg_sfr_ctrl);
  wire r_fw_nvm = (region == reg_app_flash) || (region == reg_app_eep) || r_mfr;
  wire rom_write = (region == reg_rom) && is_write;
  wire seg_ok = seg_hit && seg_perm_ok; // R13
  // only the upper manufacturer part is visible, and never writable, in system and user mode
  wire mfr_vis = r_mfr && !is_write && in_rng(eff_addr, `MBAC_MFR_VIS_LO, `MBAC_MFR_HI); // R08

  wire allow_boot = r_ded || r_sfr_hw || r_sfr_ct; // R10
  wire allow_test = r_ded || r_app || r_mfr || r_sfr_hw || r_sfr_ct; // R09
  wire allow_fw = r_ded || r_sfr_ct || (r_sfr_hw && seg_ok) || (fw_grant_q && r_fw_nvm && !is_fetch); // R10 R11
  wire allow_sys = r_app || mfr_vis || r_sfr_hw || r_sfr_ct; // R06 R12
  wire allow_user = seg_ok && (r_app || mfr_vis || r_sfr_hw); // R06 R13
  wire virt_miss = virt && is_user && !seg_hit; // R16
  wire allow_mode = is_boot ? allow_boot :
                    is_test ? allow_test :
                    is_fw ? allow_fw :
                    is_sys ? allow_sys :
                    is_user ? allow_user : 1'b0; // R12
  wire granted = vec_any || (allow_mode && !rom_write && !virt_miss);
  wire refused = req_valid && !granted; // R17

  // mode transitions: vector entry wins over a privilege drop in the same cycle
  always_comb begin
    mode_d = mode_q;
    if (vec_fw) begin
      mode_d = mode_fw; // R01
    end else if (vec_sys) begin
      mode_d = mode_sys; // R02
    end else if (mode_leave) begin
      unique case (mode_q)
        mode_boot: mode_d = test_enable ? mode_test : mode_sys;
        mode_test: mode_d = mode_sys;
        mode_fw: mode_d = mode_sys;
        mode_sys: mode_d = mode_user;
        mode_user: mode_d = mode_user;
        default: mode_d = mode_boot;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_q <= mode_boot;
      fw_grant_q <= 1'b0;
      cfg_refused_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      if (fw_grant_we && is_sys) begin
        fw_grant_q <= fw_grant_val; // R11
      end
      cfg_refused_q <= (seg_cfg_we || fw_grant_we) && !is_sys; // R07
    end
  end

  // a refused access drops the memory strobe entirely, so nothing is altered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_valid_q <= 1'b0;
      mem_kind_q <= kind_read;
      mem_addr_q <= 24'h000000;
      mem_region_q <= reg_none;
      fault_q <= 1'b0;
      fault_addr_q <= 24'h000000;
    end else begin
      mem_valid_q <= req_valid && granted; // R17
      fault_q <= refused; // R17
      if (req_valid && granted) begin
        mem_kind_q <= req_kind;
        mem_addr_q <= eff_addr;
        mem_region_q <= region;
      end
      if (refused) begin
        fault_addr_q <= req_addr;
      end
    end
  end

  // coprocessor path skips mode and segment checks, only bounding cop_offset to the shared ram size
  wire cop_in = cop_req && (cop_offset < `MBAC_CRAM_SIZE);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cop_valid_q <= 1'b0;
      cop_we_q <= 1'b0;
      cop_addr_q <= 24'h000000;
    end else begin
      cop_valid_q <= cop_in; // R15
      cop_we_q <= cop_in && cop_we;
      if (cop_in) begin
        cop_addr_q <= `MBAC_CRAM_LO + {12'h000, cop_offset}; // R15
      end
    end
  end

  assign mode = mode_q;
  assign mem_valid = mem_valid_q;
  assign mem_kind = mem_kind_q;
  assign mem_addr = mem_addr_q;
  assign mem_region = mem_region_q;
  assign fault = fault_q;
  assign fault_addr = fault_addr_q;
  assign cfg_refused = cfg_refused_q;
  assign cop_mem_valid = cop_valid_q;
  assign cop_mem_we = cop_we_q;
  assign cop_mem_addr = cop_addr_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_fw_vec;
    vec_fw |=> (mode == mode_fw) && mem_valid && !fault;
  endproperty
  a_fw_vec: assert property (p_fw_vec) else $error("firmware vector did not enter firmware mode"); // R01

  property p_sys_vec;
    vec_sys |=> (mode == mode_sys) && mem_valid;
  endproperty
  a_sys_vec: assert property (p_sys_vec) else $error("system call vector did not enter system mode"); // R02

  property p_ded_code;
    req_valid && !vec_any && (is_sys || is_user) && r_ded_code |=> fault && !mem_valid;
  endproperty
  a_ded_code: assert property (p_ded_code) else $error("dedicated code reached from system or user"); // R03

  property p_ded_eep;
    req_valid && (is_sys || is_user) && r_ded_eep |=> fault && (fault_addr == $past(req_addr));
  endproperty
  a_ded_eep: assert property (p_ded_eep) else $error("dedicated eeprom reached from system or user"); // R04

  property p_ded_ram;
    req_valid && (is_sys || is_user) && r_ded_ram |=> fault && !mem_valid && (fault_addr == $past(req_addr));
  endproperty
  a_ded_ram: assert property (p_ded_ram) else $error("dedicated ram reached from system or user"); // R05

  property p_sys_app;
    req_valid && is_sys && r_app && !virt |=> mem_valid && (mem_addr == $past(req_addr));
  endproperty
  a_sys_app: assert property (p_sys_app) else $error("system mode denied application memory"); // R06

  property p_user_noseg;
    req_valid && is_user && !vec_any && !seg_hit |=> fault && !mem_valid;
  endproperty
  a_user_noseg: assert property (p_user_noseg) else $error("user access without segment granted"); // R13

  property p_cfg_guard;
    seg_cfg_we && !is_sys |=> cfg_refused;
  endproperty
  a_cfg_guard: assert property (p_cfg_guard) else $error("segment setup accepted outside system mode"); // R07

  property p_mfr_write;
    req_valid && (is_sys || is_user) && r_mfr && is_write |=> fault;
  endproperty
  a_mfr_write: assert property (p_mfr_write) else $error("manufacturer area written outside firmware"); // R08

  property p_test_app;
    req_valid && is_test && r_app && !virt |=> mem_valid;
  endproperty
  a_test_app: assert property (p_test_app) else $error("test mode denied application memory"); // R09

  property p_boot_app;
    req_valid && (is_boot || (is_fw && is_fetch)) && r_app |=> fault;
  endproperty
  a_boot_app: assert property (p_boot_app) else $error("boot or firmware reached application memory"); // R10

  property p_fw_grant;
    req_valid && is_fw && !fw_grant_q && r_fw_nvm |=> fault;
  endproperty
  a_fw_grant: assert property (p_fw_grant) else $error("firmware reached nvm without grant"); // R11

  property p_virt_map;
    req_valid && virt && is_sys |=> mem_valid && (mem_addr == $past(virt_phys));
  endproperty
  a_virt_map: assert property (p_virt_map) else $error("virtual data not mapped to general ram"); // R16

  property p_cop;
    cop_in |=> cop_mem_valid && (cop_mem_addr >= `MBAC_CRAM_LO) && (cop_mem_addr <= `MBAC_CRAM_HI);
  endproperty
  a_cop: assert property (p_cop) else $error("coprocessor shared ram access lost"); // R15

  property p_fault_excl;
    fault |-> !mem_valid;
  endproperty
  a_fault_excl: assert property (p_fault_excl) else $error("refused access reached memory"); // R17

  c_fw_entry: cover property (is_sys && vec_fw ##1 mode == mode_fw);
  c_user_grant: cover property (req_valid && is_user && seg_ok && r_app ##1 mem_valid);
  c_fw_nvm: cover property (req_valid && is_fw && fw_grant_q && r_fw_nvm ##1 mem_valid);
  c_virt_user: cover property (req_valid && is_user && virt && seg_hit ##1 mem_valid);
endmodule // mbac_top

/* sim/mbac_cpu_model.sv */
// cpu side model: issues one access at a time and collects the controller's answer
// assumes the controller answers with mem_valid or fault on the edge that takes the request
`timescale 1ns/1ns
module mbac_cpu_model
  import mbac_pkg::*;
(
  input wire logic clk,
  output logic req_valid,
  output mbac_kind_e req_kind,
  output mbac_addr_t req_addr,
  input wire logic mem_valid,
  input wire logic fault
);
  initial begin
    req_valid = 1'b0;
    req_kind = kind_read;
    req_addr = 24'h000000;
  end

  // fields hold until the taking edge; the idle address is the inverse so a stale value never looks valid
  task automatic access(input mbac_kind_e k, input mbac_addr_t a, output logic g, output logic f);
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_addr <= a;
    @(posedge clk);
    req_valid <= 1'b0;
    req_addr <= ~a;
    #1;
    g = mem_valid;
    f = fault;
  endtask
endmodule // mbac_cpu_model

/* sim/mbac_top_tb.sv */
// self-checking bench for the access controller: table of mode/access cases, then hand tests
// assumes mbac_pkg and mbac_regs.svh are compiled first; cpu accesses go through mbac_cpu_model
`timescale 1ns/1ns
module mbac_top_tb
  import mbac_pkg::*;
;
  typedef struct packed {
    mbac_mode_e md;
    mbac_kind_e k;
    mbac_addr_t a;
    logic g;
    mbac_region_e r;
    mbac_addr_t ma;
  } mbac_row_s;
  logic clk, reset, mode_leave, test_enable, seg_cfg_we, fw_grant_we, fw_grant_val, cop_req, cop_we;
  logic [2:0] seg_cfg_idx, seg_cfg_perm;
  logic [11:0] cop_offset;
  mbac_addr_t seg_cfg_base, seg_cfg_limit, seg_cfg_xlat, req_addr, mem_addr, fault_addr, cop_mem_addr;
  logic req_valid, mem_valid, fault, cfg_refused, cop_mem_valid, cop_mem_we;
  mbac_kind_e req_kind, mem_kind;
  mbac_mode_e mode;
  mbac_region_e mem_region;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  mbac_row_s rows [0:29];

  mbac_top i_mbac_top (.clk(clk), .reset(reset), .req_valid(req_valid), .req_kind(req_kind),
    .req_addr(req_addr), .mode_leave(mode_leave), .test_enable(test_enable), .seg_cfg_we(seg_cfg_we),
    .seg_cfg_idx(seg_cfg_idx), .seg_cfg_base(seg_cfg_base), .seg_cfg_limit(seg_cfg_limit),
    .seg_cfg_xlat(seg_cfg_xlat), .seg_cfg_perm(seg_cfg_perm), .fw_grant_we(fw_grant_we),
    .fw_grant_val(fw_grant_val), .cop_req(cop_req), .cop_we(cop_we), .cop_offset(cop_offset),
    .mode(mode), .mem_valid(mem_valid), .mem_kind(mem_kind), .mem_addr(mem_addr), .mem_region(mem_region),
    .fault(fault), .fault_addr(fault_addr), .cfg_refused(cfg_refused), .cop_mem_valid(cop_mem_valid),
    .cop_mem_we(cop_mem_we), .cop_mem_addr(cop_mem_addr));
  mbac_cpu_model i_mbac_cpu_model (.clk(clk), .req_valid(req_valid), .req_kind(req_kind),
    .req_addr(req_addr), .mem_valid(mem_valid), .fault(fault));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up;
    $display("compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // a hang would otherwise stall the run; the tests need well under 3000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic try(input mbac_kind_e k, input mbac_addr_t a, input logic eg, input mbac_region_e er,
                     input mbac_addr_t ea);
    logic g, f;
    i_mbac_cpu_model.access(k, a, g, f);
    chk_bit(g, eg);
    chk_bit(f, ~eg);
    if (eg) begin
      chk_val({20'h0, mem_region}, {20'h0, er});
      chk_val(mem_addr, ea);
      chk_val({22'h0, mem_kind}, {22'h0, k});
    end else begin
      chk_val(fault_addr, a);
    end
  endtask

  task automatic leave;
    @(posedge clk);
    mode_leave <= 1'b1;
    @(posedge clk);
    mode_leave <= 1'b0;
  endtask

  // every case starts from a fresh reset, so segments and the firmware grant are clear
  task automatic go_mode(input mbac_mode_e m);
    logic g, f;
    @(posedge clk);
    reset <= 1'b1;
    test_enable <= (m == mode_test);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    if (m != mode_boot) leave();
    if (m == mode_user) leave();
    if (m == mode_fw) i_mbac_cpu_model.access(kind_fetch, 24'h000100, g, f);
  endtask

  task automatic seg(input logic [2:0] i, input mbac_addr_t b, input mbac_addr_t l, input logic [2:0] p,
                     input logic er);
    @(posedge clk);
    seg_cfg_we <= 1'b1;
    seg_cfg_idx <= i;
    seg_cfg_base <= b;
    seg_cfg_limit <= l;
    seg_cfg_xlat <= (b == 24'h800000) ? 24'h400400 : b;
    seg_cfg_perm <= p;
    @(posedge clk);
    seg_cfg_we <= 1'b0;
    #1;
    chk_bit(cfg_refused, er);
  endtask

  task automatic grant(input logic v, input logic er);
    @(posedge clk);
    fw_grant_we <= 1'b1;
    fw_grant_val <= v;
    @(posedge clk);
    fw_grant_we <= 1'b0;
    #1;
    chk_bit(cfg_refused, er);
  endtask

  task automatic cop(input logic [11:0] off, input logic w, input logic ev);
    @(posedge clk);
    cop_req <= 1'b1;
    cop_we <= w;
    cop_offset <= off;
    @(posedge clk);
    cop_req <= 1'b0;
    cop_we <= 1'b0;
    #1;
    chk_bit(cop_mem_valid, ev);
    if (ev) chk_val(cop_mem_addr, 24'h408000 + {12'h0, off});
    chk_bit(cop_mem_we, w && ev);
  endtask

  initial begin
    reset = 1'b1;
    mode_leave = 1'b0;
    test_enable = 1'b0;
    seg_cfg_we = 1'b0;
    seg_cfg_idx = 3'h0;
    seg_cfg_base = 24'h000000;
    seg_cfg_limit = 24'h000000;
    seg_cfg_xlat = 24'h000000;
    seg_cfg_perm = 3'h0;
    fw_grant_we = 1'b0;
    fw_grant_val = 1'b0;
    cop_req = 1'b0;
    cop_we = 1'b0;
    cop_offset = 12'h000;
    rows = '{
      '{mode_boot, kind_read, 24'h000000, 1'b1, reg_rom, 24'h000000},
      '{mode_boot, kind_read, 24'h110000, 1'b0, reg_none, 24'h0},
      '{mode_boot, kind_write, 24'h400300, 1'b0, reg_none, 24'h0},
      '{mode_boot, kind_fetch, 24'h100000, 1'b1, reg_ded_flash, 24'h100000},
      '{mode_boot, kind_read, 24'hff8000, 1'b1, reg_sfr_ctrl, 24'hff8000},
      '{mode_test, kind_read, 24'h110000, 1'b1, reg_app_flash, 24'h110000},
      '{mode_test, kind_write, 24'h310000, 1'b1, reg_app_eep, 24'h310000},
      '{mode_test, kind_write, 24'h400300, 1'b1, reg_gen_ram, 24'h400300},
      '{mode_test, kind_write, 24'h000010, 1'b0, reg_none, 24'h0},
      '{mode_sys, kind_read, 24'h110000, 1'b1, reg_app_flash, 24'h110000},
      '{mode_sys, kind_write, 24'h400300, 1'b1, reg_gen_ram, 24'h400300},
      '{mode_sys, kind_fetch, 24'h22ffff, 1'b1, reg_app_flash, 24'h22ffff},
      '{mode_sys, kind_read, 24'h230000, 1'b0, reg_none, 24'h0},
      '{mode_sys, kind_read, 24'h000000, 1'b0, reg_none, 24'h0},
      '{mode_sys, kind_read, 24'h107fff, 1'b0, reg_none, 24'h0},
      '{mode_sys, kind_read, 24'h3002ff, 1'b0, reg_none, 24'h0},
      '{mode_sys, kind_write, 24'h4001ff, 1'b0, reg_none, 24'h0},
      '{mode_sys, kind_read, 24'h408a7f, 1'b1, reg_cop_ram, 24'h408a7f},
      '{mode_sys, kind_read, 24'h407fff, 1'b1, reg_gen_ram, 24'h407fff},
      '{mode_sys, kind_read, 24'h300500, 1'b1, reg_mfr_eep, 24'h300500},
      '{mode_sys, kind_read, 24'h3004ff, 1'b0, reg_none, 24'h0},
      '{mode_sys, kind_write, 24'h300500, 1'b0, reg_none, 24'h0},
      '{mode_sys, kind_read, 24'h800010, 1'b1, reg_gen_ram, 24'h400210},
      '{mode_user, kind_read, 24'h110000, 1'b0, reg_none, 24'h0},
      '{mode_user, kind_read, 24'h400300, 1'b0, reg_none, 24'h0},
      '{mode_user, kind_write, 24'hff0000, 1'b0, reg_none, 24'h0},
      '{mode_fw, kind_read, 24'h110000, 1'b0, reg_none, 24'h0},
      '{mode_fw, kind_fetch, 24'h000000, 1'b1, reg_rom, 24'h000000},
      '{mode_fw, kind_write, 24'h400300, 1'b0, reg_none, 24'h0},
      '{mode_fw, kind_read, 24'h800000, 1'b0, reg_none, 24'h0}};
    repeat (20) @(posedge clk);
    chk_val({21'h0, mode}, {21'h0, mode_boot});
    chk_bit(mem_valid, 1'b0);
    chk_bit(fault, 1'b0);
    chk_bit(cop_mem_valid, 1'b0);
    chk_val({20'h0, mem_region}, {20'h0, reg_none});
    reset <= 1'b0;
    $display("reset test done");
    foreach (rows[i]) begin
      go_mode(rows[i].md);
      try(rows[i].k, rows[i].a, rows[i].g, rows[i].r, rows[i].ma);
    end
    $display("table test done");
    go_mode(mode_user);
    try(kind_fetch, 24'h000101, 1'b0, reg_none, 24'h0);
    chk_val({21'h0, mode}, {21'h0, mode_user});
    try(kind_fetch, 24'h00027c, 1'b1, reg_rom, 24'h00027c);
    chk_val({21'h0, mode}, {21'h0, mode_sys});
    try(kind_fetch, 24'h00011c, 1'b1, reg_rom, 24'h00011c);
    chk_val({21'h0, mode}, {21'h0, mode_fw});
    $display("vector test done");
    go_mode(mode_sys);
    seg(3'h0, 24'h110000, 24'h1100ff, 3'h1, 1'b0);
    seg(3'h1, 24'h800000, 24'h8000ff, 3'h3, 1'b0);
    leave();
    try(kind_read, 24'h1100ff, 1'b1, reg_app_flash, 24'h1100ff);
    try(kind_read, 24'h110100, 1'b0, reg_none, 24'h0);
    try(kind_write, 24'h110010, 1'b0, reg_none, 24'h0);
    try(kind_write, 24'h800020, 1'b1, reg_gen_ram, 24'h400420);
    seg(3'h2, 24'h120000, 24'h12ffff, 3'h7, 1'b1);
    try(kind_read, 24'h120000, 1'b0, reg_none, 24'h0);
    try(kind_fetch, 24'h000200, 1'b1, reg_rom, 24'h000200);
    seg(3'h0, 24'h110000, 24'h1100ff, 3'h0, 1'b0);
    leave();
    try(kind_read, 24'h110010, 1'b0, reg_none, 24'h0);
    $display("segment test done");
    go_mode(mode_sys);
    grant(1'b1, 1'b0);
    try(kind_fetch, 24'h000100, 1'b1, reg_rom, 24'h000100);
    try(kind_read, 24'h110000, 1'b1, reg_app_flash, 24'h110000);
    try(kind_write, 24'h310000, 1'b1, reg_app_eep, 24'h310000);
    try(kind_fetch, 24'h110000, 1'b0, reg_none, 24'h0);
    grant(1'b0, 1'b1);
    try(kind_read, 24'h110004, 1'b1, reg_app_flash, 24'h110004);
    $display("firmware grant test done");
    go_mode(mode_user);
    cop(12'h005, 1'b0, 1'b1);
    cop(12'ha7f, 1'b1, 1'b1);
    cop(12'ha80, 1'b1, 1'b0);
    $display("coprocessor test done");
    wrap_up();
  end
endmodule // mbac_top_tb
